// >>> pmbus_regs_pkg.sv
// Package: command codes, field layouts and timing constants of the register bank
package pmbus_regs_pkg;
    localparam logic [7:0] CMD_VIN_OV_FAULT = 8'h55;
    localparam logic [7:0] CMD_VIN_OV_WARN = 8'h57;
    localparam logic [7:0] CMD_BOOT_4_7 = 8'h5e;
    localparam logic [7:0] CMD_BOOT_8_D = 8'h5f;
    localparam logic [7:0] CMD_TON_DLY = 8'h60;
    localparam logic [7:0] CMD_TON_RAMP = 8'h61;
    localparam logic [7:0] CMD_TOFF_DLY = 8'h64;
    localparam logic [7:0] CMD_TOFF_RAMP = 8'h65;
    localparam logic [7:0] CMD_BOOT_E_F = 8'h6a;
    localparam logic [7:0] CMD_STATUS_ONE = 8'h78;
    localparam logic [7:0] CMD_SUMMARY = 8'h79;
    localparam logic [7:0] CMD_VOUT_FLAGS = 8'h7a;
    localparam logic [7:0] CMD_IOUT_FLAGS = 8'h7b;
    localparam logic [7:0] CMD_INPUT_FLAGS = 8'h7c;
    localparam logic [7:0] CMD_THERM_FLAGS = 8'h7d;
    localparam logic [7:0] CMD_CML_FLAGS = 8'h7e;
    localparam logic [7:0] CMD_SI_REV = 8'h80;
    localparam logic [7:0] CMD_SENSED_INPUT_VOLTAGE = 8'h88;
    localparam logic [7:0] CMD_SENSED_OUTPUT_VOLTAGE = 8'h8b;
    localparam logic [7:0] CMD_SENSED_OUTPUT_CURRENT = 8'h8c;
    localparam logic [7:0] CMD_READ_TEMP = 8'h8d;
    localparam logic [7:0] CMD_PROTO_REV = 8'h98;

    localparam int VIN_LIM_W = 7;
    localparam int BOOT_W = 10;
    localparam int DLY_W = 10;
    localparam int RAMP_W = 9;
    localparam int REF_W = 12;
    localparam logic [7:0] PROTO_REV_VALUE = 8'h33;
    localparam logic [7:0] SI_REV_VALUE = 8'h01; // Arbitrary value
    localparam logic [15:0] VIN_LIM_MASK = 16'h007f;
    localparam logic [15:0] BOOT_MASK = 16'h03ff;
    localparam logic [15:0] DLY_MASK = 16'h03ff;
    localparam logic [15:0] RAMP_MASK = 16'h01ff;
    localparam logic [7:0] VOUT_FLAG_MASK = 8'h98;
    localparam logic [7:0] IOUT_FLAG_MASK = 8'hf8;
    localparam logic [7:0] INPUT_FLAG_MASK = 8'hc8;
    localparam logic [7:0] THERM_FLAG_MASK = 8'hc1;
    localparam logic [7:0] CML_FLAG_MASK = 8'hf3;
    localparam logic [7:0] TEMP_MASK = 8'hff;

    // Summary word bit positions, then the status-byte bits behind the VOV and IOC summary bits
    localparam int SW_VOUT = 15;
    localparam int SW_IOUT = 14;
    localparam int SW_INPUT = 13;
    localparam int SW_PGOOD = 11;
    localparam int SW_WDOG = 8;
    localparam int SW_BUSY = 7;
    localparam int SW_OFF = 6;
    localparam int SW_VOV = 5;
    localparam int SW_IOC = 4;
    localparam int SW_TEMP = 2;
    localparam int SW_CML = 1;
    localparam int SW_PSTAGE = 0;
    localparam int VOUT_OV_BIT = 7;
    localparam int IOUT_OC_BIT = 7;

    // 0.1 ms per count at 50 MHz
    localparam int CLK_HZ = 50_000_000;
    localparam int TICK_US = 100;
    localparam int TICK_CYC = CLK_HZ / 1_000_000 * TICK_US;
    localparam int TICK_W = 13;

    // Boot step is four reference steps
    localparam int BOOT_SHIFT = 2;
    localparam logic [3:0] NIB_GRP_8 = 4'h8;
    localparam logic [3:0] NIB_GRP_E = 4'he;
    localparam logic [3:0] NIB_GRP_4 = 4'h4;

    typedef struct packed {
        logic [7:0] vout;
        logic [7:0] iout;
        logic [7:0] input_s;
        logic [7:0] therm;
        logic [7:0] comm_memory_logic_flag;
        logic power_good;
        logic watchdog;
        logic busy;
        logic power_stage;
    } fault_flags_t;

    typedef struct packed {
        logic [15:0] vin;
        logic [15:0] vout;
        logic [15:0] iout;
        logic [15:0] temp;
    } telemetry_t;

    typedef enum logic [4:0] {
        SEQ_OFF = 5'b00001,
        SEQ_ON_DLY = 5'b00010,
        SEQ_RISE = 5'b00100,
        SEQ_ON = 5'b01000,
        SEQ_FALL = 5'b10000
    } seq_state_t;
endpackage

// >>> pmbus_limit_status_telemetry_regs.sv
// Register bank with boot-voltage selection and soft start/stop sequencer
module pmbus_limit_status_telemetry_regs #(
    parameter int TICK_CYCLES = pmbus_regs_pkg::TICK_CYC
) (
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire logic i_wr_en,
    input wire logic i_rd_en,
    input wire logic [7:0] i_cmd,
    input wire logic [15:0] i_wr_data,
    input wire logic [1:0] i_output_voltage_format,
    input wire logic i_address_source_select,
    input wire logic i_boot_voltage_source_select,
    input wire logic [3:0] i_addr_nibble,
    input wire logic [pmbus_regs_pkg::REF_W-1:0] i_register_boot_voltage,
    input wire logic [pmbus_regs_pkg::REF_W-1:0] i_target_ref,
    input wire logic i_start,
    input wire logic i_stop,
    input wire pmbus_regs_pkg::fault_flags_t i_flags,
    input wire pmbus_regs_pkg::telemetry_t i_telem,
    output logic [15:0] o_rd_data,
    output logic o_rd_valid,
    output logic o_cmd_known,
    output logic [pmbus_regs_pkg::REF_W-1:0] o_ref,
    output logic [pmbus_regs_pkg::REF_W-1:0] o_boot_ref,
    output logic o_output_off,
    output logic [pmbus_regs_pkg::VIN_LIM_W-1:0] o_vin_ov_fault_threshold,
    output logic [pmbus_regs_pkg::VIN_LIM_W-1:0] o_vin_ov_warn_threshold
);
    import pmbus_regs_pkg::*;

    // Writable registers
    logic [VIN_LIM_W-1:0] ovf_q, ovf_d, ovw_q, ovw_d;
    logic [BOOT_W-1:0] boot47_q, boot47_d, boot8d_q, boot8d_d, bootef_q, bootef_d;
    logic [DLY_W-1:0] ton_dly_q, ton_dly_d, toff_dly_q, toff_dly_d;
    logic [RAMP_W-1:0] ton_ramp_q, ton_ramp_d, toff_ramp_q, toff_ramp_d;

    always_comb begin
        ovf_d = ovf_q;
        ovw_d = ovw_q;
        boot47_d = boot47_q;
        boot8d_d = boot8d_q;
        bootef_d = bootef_q;
        ton_dly_d = ton_dly_q;
        ton_ramp_d = ton_ramp_q;
        toff_dly_d = toff_dly_q;
        toff_ramp_d = toff_ramp_q;
        // Writes refused while the nonvolatile copy runs
        if (i_wr_en && !i_flags.busy) begin
            unique case (i_cmd)
                CMD_VIN_OV_FAULT: ovf_d = i_wr_data[VIN_LIM_W-1:0];
                CMD_VIN_OV_WARN: ovw_d = i_wr_data[VIN_LIM_W-1:0];
                CMD_BOOT_4_7: boot47_d = i_wr_data[BOOT_W-1:0];
                CMD_BOOT_8_D: boot8d_d = i_wr_data[BOOT_W-1:0];
                CMD_BOOT_E_F: bootef_d = i_wr_data[BOOT_W-1:0];
                CMD_TON_DLY: ton_dly_d = i_wr_data[DLY_W-1:0];
                CMD_TON_RAMP: ton_ramp_d = i_wr_data[RAMP_W-1:0];
                CMD_TOFF_DLY: toff_dly_d = i_wr_data[DLY_W-1:0];
                CMD_TOFF_RAMP: toff_ramp_d = i_wr_data[RAMP_W-1:0];
                default: ; // Read-only and unknown codes change nothing
            endcase
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            ovf_q <= '0;
            ovw_q <= '0;
            boot47_q <= '0;
            boot8d_q <= '0;
            bootef_q <= '0;
            ton_dly_q <= '0;
            ton_ramp_q <= '0;
            toff_dly_q <= '0;
            toff_ramp_q <= '0;
        end else begin
            ovf_q <= ovf_d;
            ovw_q <= ovw_d;
            boot47_q <= boot47_d;
            boot8d_q <= boot8d_d;
            bootef_q <= bootef_d;
            ton_dly_q <= ton_dly_d;
            ton_ramp_q <= ton_ramp_d;
            toff_dly_q <= toff_dly_d;
            toff_ramp_q <= toff_ramp_d;
        end
    end

    // Pin-strap synchroniser for the address nibble
    logic [3:0] nib_s1_q, nib_s2_q;
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            nib_s1_q <= '0;
            nib_s2_q <= '0;
        end else begin
            nib_s1_q <= i_addr_nibble;
            nib_s2_q <= nib_s1_q;
        end
    end

    // Boot target: boot code shifted up two bits into reference steps when boot source set, address source clear, nibble >= 4; else register boot voltage
    logic [BOOT_W-1:0] boot_sel;
    logic [REF_W-1:0] boot_d, boot_q;
    always_comb begin
        if (nib_s2_q >= NIB_GRP_E) begin
            boot_sel = bootef_q;
        end else if (nib_s2_q >= NIB_GRP_8) begin
            boot_sel = boot8d_q;
        end else begin
            boot_sel = boot47_q;
        end
        if (!i_address_source_select && i_boot_voltage_source_select && nib_s2_q >= NIB_GRP_4) begin
            boot_d = REF_W'({boot_sel, {BOOT_SHIFT{1'b0}}});
        end else begin
            boot_d = i_register_boot_voltage;
        end
    end

    // Power sequencer
    seq_state_t st_q, st_d;
    logic [TICK_W-1:0] tick_q, tick_d;
    logic [DLY_W-1:0] cnt_q, cnt_d;
    logic [REF_W-1:0] ref_q, ref_d, start_q, start_d;
    logic tick;
    logic [REF_W+RAMP_W-1:0] span;

    assign tick = (tick_q == TICK_W'(TICK_CYCLES - 1));

    always_comb begin
        st_d = st_q;
        cnt_d = cnt_q;
        ref_d = ref_q;
        start_d = start_q;
        tick_d = tick ? '0 : tick_q + 1'b1;
        span = '0;
        unique case (st_q)
            SEQ_OFF: begin
                if (i_start) begin
                    st_d = SEQ_ON_DLY;
                    cnt_d = '0;
                    tick_d = '0;
                end
            end
            SEQ_ON_DLY: begin
                if (cnt_q >= ton_dly_q) begin
                    st_d = SEQ_RISE;
                    cnt_d = '0;
                    start_d = ref_q;
                end else if (tick) begin
                    cnt_d = cnt_q + 1'b1;
                end
            end
            SEQ_RISE: begin
                // A zero ramp count leaves at once, so the divider never sees zero
                if (cnt_q >= DLY_W'(ton_ramp_q)) begin
                    st_d = SEQ_ON;
                    ref_d = boot_q;
                end else begin
                    // Linear interpolation between start and target
                    span = (REF_W+RAMP_W)'(boot_q - start_q) * (REF_W+RAMP_W)'(cnt_q);
                    ref_d = start_q + REF_W'(span / (REF_W+RAMP_W)'(ton_ramp_q));
                    if (tick) begin
                        cnt_d = cnt_q + 1'b1;
                    end
                end
            end
            SEQ_ON: begin
                ref_d = i_target_ref;
                if (i_stop) begin
                    st_d = SEQ_FALL;
                    cnt_d = '0;
                    tick_d = '0;
                    start_d = ref_q;
                end
            end
            SEQ_FALL: begin
                // Turn-off delay counts first, then the fall ramp
                if (cnt_q < toff_dly_q) begin
                    if (tick) begin
                        cnt_d = cnt_q + 1'b1;
                    end
                end else if (cnt_q - toff_dly_q >= DLY_W'(toff_ramp_q)) begin
                    st_d = SEQ_OFF;
                    ref_d = '0;
                end else begin
                    span = (REF_W+RAMP_W)'(start_q) * (REF_W+RAMP_W)'(cnt_q - toff_dly_q);
                    ref_d = start_q - REF_W'(span / (REF_W+RAMP_W)'(toff_ramp_q));
                    if (tick) begin
                        cnt_d = cnt_q + 1'b1;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            st_q <= SEQ_OFF;
            tick_q <= '0;
            cnt_q <= '0;
            ref_q <= '0;
            start_q <= '0;
            boot_q <= '0;
        end else begin
            st_q <= st_d;
            tick_q <= tick_d;
            cnt_q <= cnt_d;
            ref_q <= ref_d;
            start_q <= start_d;
            boot_q <= boot_d;
        end
    end

    // Status composition
    logic [7:0] vout_f, iout_f, inp_f, therm_f, cml_f;
    logic [15:0] summary;
    logic off_now;
    assign vout_f = i_flags.vout & VOUT_FLAG_MASK;
    assign iout_f = i_flags.iout & IOUT_FLAG_MASK;
    assign inp_f = i_flags.input_s & INPUT_FLAG_MASK;
    assign therm_f = i_flags.therm & THERM_FLAG_MASK;
    assign cml_f = i_flags.comm_memory_logic_flag & CML_FLAG_MASK;
    // Power still flows while the reference winds down
    assign off_now = (st_q == SEQ_OFF) || (st_q == SEQ_ON_DLY);

    always_comb begin
        summary = '0;
        summary[SW_VOUT] = |vout_f;
        summary[SW_IOUT] = |iout_f;
        summary[SW_INPUT] = |inp_f;
        summary[SW_PGOOD] = i_flags.power_good;
        summary[SW_WDOG] = i_flags.watchdog;
        summary[SW_BUSY] = i_flags.busy;
        summary[SW_OFF] = off_now;
        summary[SW_VOV] = vout_f[VOUT_OV_BIT];
        summary[SW_IOC] = iout_f[IOUT_OC_BIT];
        summary[SW_TEMP] = |therm_f;
        summary[SW_CML] = |cml_f;
        summary[SW_PSTAGE] = i_flags.power_stage;
    end

    // Read mux; reserved bits stay zero
    logic [15:0] rd_word;
    logic code_known;
    logic [15:0] rd_d, rd_q;
    logic known_d, known_q;
    logic rv_d, rv_q;
    always_comb begin
        rd_word = '0;
        code_known = 1'b1;
        unique case (i_cmd)
            CMD_VIN_OV_FAULT: rd_word = 16'(ovf_q) & VIN_LIM_MASK;
            CMD_VIN_OV_WARN: rd_word = 16'(ovw_q) & VIN_LIM_MASK;
            CMD_BOOT_4_7: rd_word = 16'(boot47_q) & BOOT_MASK;
            CMD_BOOT_8_D: rd_word = 16'(boot8d_q) & BOOT_MASK;
            CMD_BOOT_E_F: rd_word = 16'(bootef_q) & BOOT_MASK;
            CMD_TON_DLY: rd_word = 16'(ton_dly_q) & DLY_MASK;
            CMD_TON_RAMP: rd_word = 16'(ton_ramp_q) & RAMP_MASK;
            CMD_TOFF_DLY: rd_word = 16'(toff_dly_q) & DLY_MASK;
            CMD_TOFF_RAMP: rd_word = 16'(toff_ramp_q) & RAMP_MASK;
            CMD_STATUS_ONE: rd_word = {8'h00, summary[7:0]};
            CMD_SUMMARY: rd_word = summary;
            CMD_VOUT_FLAGS: rd_word = {8'h00, vout_f};
            CMD_IOUT_FLAGS: rd_word = {8'h00, iout_f};
            CMD_INPUT_FLAGS: rd_word = {8'h00, inp_f};
            CMD_THERM_FLAGS: rd_word = {8'h00, therm_f};
            CMD_CML_FLAGS: rd_word = {8'h00, cml_f};
            CMD_SI_REV: rd_word = {8'h00, SI_REV_VALUE};
            CMD_SENSED_INPUT_VOLTAGE: rd_word = i_telem.vin;
            CMD_SENSED_OUTPUT_VOLTAGE: rd_word = i_telem.vout;
            CMD_SENSED_OUTPUT_CURRENT: rd_word = i_telem.iout;
            CMD_READ_TEMP: rd_word = {8'h00, i_telem.temp[7:0] & TEMP_MASK};
            CMD_PROTO_REV: rd_word = {8'h00, PROTO_REV_VALUE};
            default: code_known = 1'b0;
        endcase
    end

    // Read data holds until the next read; the mapped flag follows any access
    always_comb begin
        rd_d = i_rd_en ? rd_word : rd_q;
        known_d = (i_rd_en || i_wr_en) ? code_known : known_q;
        rv_d = i_rd_en;
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            rd_q <= '0;
            known_q <= 1'b0;
            rv_q <= 1'b0;
        end else begin
            rd_q <= rd_d;
            known_q <= known_d;
            rv_q <= rv_d;
        end
    end

    // Sensed output voltage passes through; the format input is not used anywhere
    logic off_q;
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            off_q <= 1'b1;
        end else begin
            off_q <= off_now;
        end
    end

    assign o_rd_data = rd_q;
    assign o_rd_valid = rv_q;
    assign o_cmd_known = known_q;
    assign o_ref = ref_q;
    assign o_boot_ref = boot_q;
    assign o_output_off = off_q;
    assign o_vin_ov_fault_threshold = ovf_q;
    assign o_vin_ov_warn_threshold = ovw_q;
endmodule

// >>> pmbus_regs_props.sv
// Checker of the register bank port behaviour
module pmbus_regs_props (
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire logic i_wr_en,
    input wire logic i_rd_en,
    input wire logic [7:0] i_cmd,
    input wire logic [15:0] i_wr_data,
    input wire pmbus_regs_pkg::fault_flags_t i_flags,
    input wire pmbus_regs_pkg::telemetry_t i_telem,
    input wire logic [15:0] o_rd_data,
    input wire logic o_rd_valid,
    input wire logic o_cmd_known,
    input wire logic o_output_off,
    input wire logic [pmbus_regs_pkg::VIN_LIM_W-1:0] o_vin_ov_fault_threshold,
    input wire logic [pmbus_regs_pkg::VIN_LIM_W-1:0] o_vin_ov_warn_threshold
);
    import pmbus_regs_pkg::*;
    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (i_rst);

    a_read_answers: assert property (i_rd_en |=> o_rd_valid ##1 (!o_rd_valid || $past(i_rd_en)))
        else $error("read not answered by one valid pulse");
    a_no_stray_valid: assert property (!i_rd_en |=> !o_rd_valid)
        else $error("valid without a read");
    a_proto_rev_const: assert property (i_rd_en && i_cmd == CMD_PROTO_REV |=> o_rd_data == 16'h0033)
        else $error("protocol revision wrong");
    a_fault_thr_write: assert property (i_wr_en && !i_flags.busy && i_cmd == CMD_VIN_OV_FAULT
        |=> o_vin_ov_fault_threshold == $past(i_wr_data[6:0]))
        else $error("fault threshold not taken");
    a_warn_thr_write: assert property (i_wr_en && !i_flags.busy && i_cmd == CMD_VIN_OV_WARN
        |=> o_vin_ov_warn_threshold == $past(i_wr_data[6:0]))
        else $error("warn threshold not taken");
    a_busy_refuses: assert property (i_wr_en && i_flags.busy
        |=> $stable(o_vin_ov_fault_threshold) && $stable(o_vin_ov_warn_threshold))
        else $error("write taken while busy");
    a_vout_flag_bits: assert property (i_rd_en && i_cmd == CMD_VOUT_FLAGS
        |=> o_rd_data == {8'h00, $past(i_flags.vout) & 8'h98})
        else $error("output voltage flags wrong");
    a_input_flag_bits: assert property (i_rd_en && i_cmd == CMD_INPUT_FLAGS
        |=> o_rd_data == {8'h00, $past(i_flags.input_s) & 8'hc8})
        else $error("input flags wrong");
    a_delay_reserved: assert property (i_rd_en && i_cmd == CMD_TON_DLY |=> o_rd_data[15:10] == 6'h00)
        else $error("reserved bits not zero");
    a_iout_telem: assert property (i_rd_en && i_cmd == CMD_SENSED_OUTPUT_CURRENT |=> o_rd_data == $past(i_telem.iout))
        else $error("output current read wrong");
    a_unknown_code: assert property (i_rd_en && i_cmd == 8'h00 |=> !o_cmd_known)
        else $error("unmapped code reported known");
    a_summary_off_bit: assert property (i_rd_en && i_cmd == CMD_SUMMARY |=> o_rd_data[SW_OFF] == o_output_off)
        else $error("summary off bit disagrees with output off");
    a_summary_reserved: assert property (i_rd_en && i_cmd == CMD_SUMMARY
        |=> o_rd_data[12] == 1'b0 && o_rd_data[10:9] == 2'b00 && o_rd_data[3] == 1'b0)
        else $error("summary reserved bits not zero");

    c_proto_read: cover property (i_rd_en && i_cmd == CMD_PROTO_REV);
    c_busy_write: cover property (i_wr_en && i_flags.busy);
    c_power_on: cover property ($fell(o_output_off));
endmodule

bind pmbus_limit_status_telemetry_regs pmbus_regs_props i_pmbus_regs_props (
    .i_ref_clk(i_ref_clk),
    .i_rst(i_rst),
    .i_wr_en(i_wr_en),
    .i_rd_en(i_rd_en),
    .i_cmd(i_cmd),
    .i_wr_data(i_wr_data),
    .i_flags(i_flags),
    .i_telem(i_telem),
    .o_rd_data(o_rd_data),
    .o_rd_valid(o_rd_valid),
    .o_cmd_known(o_cmd_known),
    .o_output_off(o_output_off),
    .o_vin_ov_fault_threshold(o_vin_ov_fault_threshold),
    .o_vin_ov_warn_threshold(o_vin_ov_warn_threshold)
);

// >>> pmbus_host_model.sv
// Host model issuing register reads and writes
module pmbus_host_model (
    input wire logic i_ref_clk,
    input wire logic [15:0] i_rd_data,
    input wire logic i_rd_valid,
    output logic o_wr_en,
    output logic o_rd_en,
    output logic [7:0] o_cmd,
    output logic [15:0] o_wr_data
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        o_wr_en = 1'b0;
        o_rd_en = 1'b0;
        o_cmd = 8'h00;
        o_wr_data = 16'h0000;
    end

    // Called just after a rising edge; returns one edge after release
    task automatic wr(input logic [7:0] c, input logic [15:0] d);
        o_cmd <= c;
        o_wr_data <= d;
        o_wr_en <= 1'b1;
        @(posedge i_ref_clk);
        o_wr_en <= 1'b0;
        o_wr_data <= ~d;
        @(posedge i_ref_clk);
    endtask

    task automatic rd(input logic [7:0] c, output logic [15:0] d);
        o_cmd <= c;
        o_rd_en <= 1'b1;
        @(posedge i_ref_clk);
        o_rd_en <= 1'b0;
        o_cmd <= ~c;
        @(posedge i_ref_clk);
        d = (i_rd_valid === 1'b1) ? i_rd_data : 16'hxxxx;
    endtask
endmodule

// >>> tb_top.sv
// Testbench of the register bank
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import pmbus_regs_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic wr_en, rd_en, cmd_known, start = 1'b0, stop = 1'b0;
    logic rd_valid, output_off, addr_src = 1'b0, boot_src = 1'b1;
    logic [7:0] cmd;
    logic [15:0] wr_data, rd_data, v;
    logic [1:0] fmt = 2'b01;
    logic [3:0] nibble = 4'h8;
    logic [11:0] reg_boot = 12'h123, target = 12'h048, ref_v, boot_ref;
    logic [6:0] fault_thr, warn_thr;
    fault_flags_t flags = '0;
    telemetry_t telem = {16'h1234, 16'h2345, 16'h3456, 16'h00a7};
    int fails = 0;
    int total_checks = 0;
    int cyc = 0;

    always #10 clk = ~clk;

    pmbus_host_model i_pmbus_host_model (.i_ref_clk(clk), .i_rd_data(rd_data), .i_rd_valid(rd_valid),
        .o_wr_en(wr_en), .o_rd_en(rd_en), .o_cmd(cmd), .o_wr_data(wr_data));

    pmbus_limit_status_telemetry_regs #(.TICK_CYCLES(4)) i_pmbus_limit_status_telemetry_regs (
        .i_ref_clk(clk), .i_rst(rst), .i_wr_en(wr_en), .i_rd_en(rd_en), .i_cmd(cmd), .i_wr_data(wr_data),
        .i_output_voltage_format(fmt), .i_address_source_select(addr_src),
        .i_boot_voltage_source_select(boot_src), .i_addr_nibble(nibble), .i_register_boot_voltage(reg_boot),
        .i_target_ref(target), .i_start(start), .i_stop(stop), .i_flags(flags), .i_telem(telem),
        .o_rd_data(rd_data), .o_rd_valid(rd_valid), .o_cmd_known(cmd_known), .o_ref(ref_v),
        .o_boot_ref(boot_ref), .o_output_off(output_off), .o_vin_ov_fault_threshold(fault_thr),
        .o_vin_ov_warn_threshold(warn_thr));

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("Error %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic rdchk(input logic [7:0] c, input logic [15:0] exp);
        logic [15:0] d;
        i_pmbus_host_model.rd(c, d);
        chk(d, exp);
    endtask

    task automatic conclude();
        $display("Checks %0d, mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            fails++;
            conclude();
        end
    end

    // Writable registers keep only their documented field
    task automatic t_rw_fields();
        logic [7:0] cmds [9] = '{CMD_VIN_OV_FAULT, CMD_VIN_OV_WARN, CMD_BOOT_4_7, CMD_BOOT_8_D,
            CMD_TON_DLY, CMD_TON_RAMP, CMD_TOFF_DLY, CMD_TOFF_RAMP, CMD_BOOT_E_F};
        logic [15:0] msk [9] = '{16'h007f, 16'h007f, 16'h03ff, 16'h03ff, 16'h03ff, 16'h01ff, 16'h03ff,
            16'h01ff, 16'h03ff};
        logic [15:0] pat [2] = '{16'hffff, 16'h8a55};
        for (int p = 0; p < 2; p++) begin
            for (int i = 0; i < 9; i++) begin
                i_pmbus_host_model.wr(cmds[i], pat[p]);
                rdchk(cmds[i], pat[p] & msk[i]);
            end
        end
        chk({9'h000, fault_thr}, 16'h0055);
        chk({9'h000, warn_thr}, 16'h0055);
    endtask

    // Read-only places, unmapped code and busy refusal
    task automatic t_refusals();
        i_pmbus_host_model.wr(CMD_PROTO_REV, 16'h0000);
        rdchk(CMD_PROTO_REV, 16'h0033);
        i_pmbus_host_model.wr(CMD_SENSED_OUTPUT_CURRENT, 16'h0000);
        rdchk(CMD_SENSED_OUTPUT_CURRENT, 16'h3456);
        rdchk(8'h00, 16'h0000);
        chk({15'h0, cmd_known}, 16'h0000);
        flags <= '1;
        i_pmbus_host_model.wr(CMD_VIN_OV_FAULT, 16'h0011);
        rdchk(CMD_VIN_OV_FAULT, 16'h0055);
    endtask

    // Status bytes and summary word with every flag up, then none
    task automatic t_status();
        rdchk(CMD_VOUT_FLAGS, 16'h0098);
        rdchk(CMD_IOUT_FLAGS, 16'h00f8);
        rdchk(CMD_INPUT_FLAGS, 16'h00c8);
        rdchk(CMD_THERM_FLAGS, 16'h00c1);
        rdchk(CMD_CML_FLAGS, 16'h00f3);
        rdchk(CMD_SUMMARY, 16'he9f7);
        rdchk(CMD_STATUS_ONE, 16'h00f7);
        flags <= '0;
        @(posedge clk);
        rdchk(CMD_SUMMARY, 16'h0040);
        rdchk(CMD_SENSED_INPUT_VOLTAGE, 16'h1234);
        rdchk(CMD_READ_TEMP, 16'h00a7);
        for (int f = 0; f < 4; f++) begin
            fmt <= 2'(f);
            rdchk(CMD_SENSED_OUTPUT_VOLTAGE, 16'h2345);
        end
    endtask

    // Boot selection, start delay and ramp, stop to zero
    task automatic t_sequence();
        int n;
        i_pmbus_host_model.wr(CMD_BOOT_8_D, 16'hfc12);
        i_pmbus_host_model.wr(CMD_BOOT_E_F, 16'h03ff);
        i_pmbus_host_model.wr(CMD_TON_DLY, 16'h0002);
        i_pmbus_host_model.wr(CMD_TON_RAMP, 16'h0002);
        i_pmbus_host_model.wr(CMD_TOFF_DLY, 16'h0001);
        i_pmbus_host_model.wr(CMD_TOFF_RAMP, 16'h0001);
        repeat (4) @(posedge clk);
        chk({4'h0, boot_ref}, 16'h0048);
        nibble <= 4'he;
        repeat (4) @(posedge clk);
        chk({4'h0, boot_ref}, 16'h0ffc);
        addr_src <= 1'b1;
        repeat (4) @(posedge clk);
        chk({4'h0, boot_ref}, 16'h0123);
        addr_src <= 1'b0;
        nibble <= 4'h8;
        repeat (4) @(posedge clk);
        start <= 1'b1;
        @(posedge clk);
        start <= 1'b0;
        n = 1;
        while (output_off !== 1'b0 && n < 100) begin
            @(posedge clk);
            n++;
        end
        chk({15'h0, n >= 8 && n <= 12}, 16'h0001);
        n = 0;
        while (ref_v !== 12'h048 && n < 100) begin
            @(posedge clk);
            n++;
        end
        chk({15'h0, n >= 4 && n <= 12}, 16'h0001);
        rdchk(CMD_SUMMARY, 16'h0000);
        stop <= 1'b1;
        @(posedge clk);
        stop <= 1'b0;
        n = 1;
        while (ref_v !== 12'h000 && n < 100) begin
            @(posedge clk);
            n++;
        end
        chk({15'h0, n >= 4 && n <= 12}, 16'h0001);
        repeat (2) @(posedge clk);
        chk({15'h0, output_off}, 16'h0001);
    endtask

    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_rw_fields();
        t_refusals();
        t_status();
        t_sequence();
        conclude();
    end
endmodule
